// >>> reset_and_alt_vector_address.sv
// Reset start address and trap / interrupt vector address generator.
// Assumes request lines and configuration levels come from logic on
// ref_clk_i, so none of them is synchronised here.
//
// What this block does
// - Reset clears state and forces the program counter to address zero.
// - Reset bypasses vector logic; no vector is offered during or for reset.
// - Oscillator fail, address error, hard trap at base plus 4, 6, 8.
// - Stack error at base plus 0xA, math error at base plus 0xC.
// - Soft trap at base plus 0x10; slots 0, 2, 0xE, 0x12 never chosen.
// - Interrupt n sits at base plus 0x14 plus twice n, up to 0x1FE.
// - Lower slot address wins; traps before interrupts, lower index first.
// - Alternate base is boot segment limit minus one, times 0x400.
// - Alternate table used only with config bit and runtime enable both set.
// - Otherwise vectors come from the primary table, first slot at 4.
// - Alternate table needs a boot segment of at least two pages.
`timescale 1ns/1ps

module reset_and_alt_vector_address
  import vec_addr_pkg::*;
#(
  parameter int unsigned N_IRQ = NUM_IRQS
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [LIMIT_W-1:0]   boot_segment_limit_i,
  input  wire logic                 alt_table_config_bit_i,
  input  wire logic                 alt_table_enable_i,
  input  wire logic [NUM_TRAPS-1:0] trap_req_i,
  input  wire logic [N_IRQ-1:0]     irq_req_i,
  input  wire logic                 vec_fetch_req_i,
  output logic                      pc_force_o,
  output logic [ADDR_W-1:0]         pc_start_o,
  output logic                      vec_pending_o,
  output logic                      vec_is_trap_o,
  output logic [SRC_W-1:0]          vec_src_o,
  output logic [ADDR_W-1:0]         vec_addr_o,
  output logic                      alt_active_o,
  output logic                      vec_grant_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Lowest set bit wins: lower slot address means higher priority
  function automatic logic [SRC_W-1:0] first_set(input logic [255:0] v);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = 255; i >= 0; i--) begin
      if (v[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction

  // Trap slot offsets; reserved slots have no entry at all
  function automatic logic [ADDR_W-1:0] trap_ofs(input logic [SRC_W-1:0] t);
    logic [ADDR_W-1:0] o;
    o = OFS_OSC_FAIL;
    case (t)
      SRC_W'(TRAP_OSC_FAIL):  o = OFS_OSC_FAIL;
      SRC_W'(TRAP_ADDR_ERR):  o = OFS_ADDR_ERR;
      SRC_W'(TRAP_HARD):      o = OFS_HARD_TRAP;
      SRC_W'(TRAP_STACK_ERR): o = OFS_STACK_ERR;
      SRC_W'(TRAP_MATH_ERR):  o = OFS_MATH_ERR;
      SRC_W'(TRAP_SOFT):      o = OFS_SOFT_TRAP;
      default:                o = OFS_OSC_FAIL;
    endcase
    return o;
  endfunction

  // ----------------------------------------------------------------------
  // Table base selection
  // ----------------------------------------------------------------------
  logic                 big_boot;
  logic                 alt_ok;
  logic [LIMIT_W-1:0]   last_page;
  logic [ADDR_W-1:0]    alt_base;
  logic [ADDR_W-1:0]    base;

  // A one-page boot segment cannot host the table, so it stays primary
  assign big_boot  = boot_segment_limit_i >= MIN_BOOT_PAGES;
  assign alt_ok    = alt_table_config_bit_i & alt_table_enable_i
                     & big_boot;
  assign last_page = boot_segment_limit_i - LIMIT_W'(1);
  assign alt_base  = ADDR_W'({last_page, {PAGE_SHIFT{1'b0}}});
  assign base      = alt_ok ? alt_base : PRIMARY_BASE;

  // ----------------------------------------------------------------------
  // Priority and offset
  // ----------------------------------------------------------------------
  logic                 any_trap;
  logic                 any_irq;
  logic [SRC_W-1:0]     trap_idx;
  logic [SRC_W-1:0]     irq_idx;
  logic [SRC_W-1:0]     src_d;
  logic [ADDR_W-1:0]    irq_ofs;
  logic [ADDR_W-1:0]    ofs_d;

  // Traps sit below every interrupt slot, so they win outright
  assign any_trap = |trap_req_i;
  assign any_irq  = |irq_req_i;
  assign trap_idx = first_set(256'(trap_req_i));
  assign irq_idx  = first_set(256'(irq_req_i));
  assign src_d    = any_trap ? trap_idx : irq_idx;
  // Two address units per slot, so the index is doubled
  assign irq_ofs  = OFS_IRQ0 + ADDR_W'({irq_idx, 1'b0});
  assign ofs_d    = any_trap ? trap_ofs(trap_idx) : irq_ofs;

  // ----------------------------------------------------------------------
  // Registered vector offer
  // ----------------------------------------------------------------------
  logic                 pending_q;
  logic                 is_trap_q;
  logic [SRC_W-1:0]     src_q;
  logic [ADDR_W-1:0]    addr_q;
  logic                 alt_q;
  logic                 force_q;

  // Re-evaluated every edge so the address is ready when the CPU asks
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending_q <= 1'b0;
      is_trap_q <= 1'b0;
      src_q     <= '0;
      addr_q    <= RESET_ADDR;
      alt_q     <= 1'b0;
    end else begin
      pending_q <= any_trap | any_irq;
      is_trap_q <= any_trap;
      src_q     <= src_d;
      addr_q    <= base + ofs_d;
      alt_q     <= alt_ok;
    end
  end

  // Program counter force: held through reset and one edge beyond
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      force_q <= 1'b1;
    end else begin
      force_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pc_force_o    = force_q;
  assign pc_start_o    = RESET_ADDR;
  assign vec_pending_o = pending_q;
  assign vec_is_trap_o = is_trap_q;
  assign vec_src_o     = src_q;
  assign vec_addr_o    = addr_q;
  assign alt_active_o  = alt_q;
  // No grant while the reset force stands: reset is not an exception
  assign vec_grant_o   = vec_fetch_req_i & pending_q & ~force_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_trap_seen;
    trap_req_i != '0;
  endsequence

  sequence s_irq_only;
    trap_req_i == '0 && irq_req_i != '0;
  endsequence

  AST_RESET_FORCE: assert property (@(posedge ref_clk_i)
    $fell(reset_i) |-> pc_force_o && pc_start_o == RESET_ADDR ##1 !pc_force_o)
    else $error("pc force not released one edge after reset");

  AST_NO_RESET_VECTOR: assert property (@(posedge ref_clk_i)
    pc_force_o |-> !vec_grant_o && !vec_pending_o)
    else $error("vector offered while reset force stands");

  AST_OSC_FIRST: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    trap_req_i[TRAP_OSC_FAIL] |=> vec_addr_o == $past(base) + OFS_OSC_FAIL)
    else $error("oscillator fail trap address wrong");

  AST_MATH_SLOT: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    trap_req_i == 6'h10 |=> vec_addr_o == $past(base) + OFS_MATH_ERR)
    else $error("math error trap address wrong");

  AST_RESERVED_SLOT: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    s_trap_seen |=> (vec_addr_o - $past(base)) != 24'h000000
      && (vec_addr_o - $past(base)) != 24'h000002
      && (vec_addr_o - $past(base)) != 24'h00000E
      && (vec_addr_o - $past(base)) != 24'h000012)
    else $error("reserved slot selected");

  AST_IRQ_SLOT: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    s_irq_only |=> vec_addr_o == $past(base) + OFS_IRQ0
      + {15'h0000, vec_src_o, 1'b0} && vec_addr_o - $past(base)
      <= OFS_IRQ_LAST)
    else $error("interrupt slot address wrong");

  AST_TRAP_WINS: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    s_trap_seen ##0 (irq_req_i != '0) |=> vec_is_trap_o
      && (vec_addr_o - $past(base)) < OFS_IRQ0)
    else $error("interrupt beat a pending trap");

  AST_ALT_BASE: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    alt_ok |-> base == ADDR_W'((32'(boot_segment_limit_i) - 32'h1)
      * 32'h400))
    else $error("alternate base not limit minus one pages");

  AST_ALT_GATE: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    alt_active_o |-> $past(alt_table_config_bit_i)
      && $past(alt_table_enable_i))
    else $error("alternate table active without both enables");

  AST_PRIMARY: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    (!alt_ok) and s_trap_seen |=> vec_addr_o >= PRIMARY_FIRST
      && vec_addr_o < OFS_IRQ0)
    else $error("primary table address wrong");

  AST_TWO_PAGES: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    boot_segment_limit_i < MIN_BOOT_PAGES |=> !alt_active_o)
    else $error("alternate table with short boot segment");

  AST_GRANT_ADDR: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    vec_grant_o |-> vec_pending_o && vec_addr_o >= $past(base))
    else $error("grant without a valid offered address");

endmodule // reset_and_alt_vector_address

// >>> vec_addr_pkg.sv
// Constants for the reset start address and vector address generator.
// Assumes a 24-bit program address space addressed in words of two.
package vec_addr_pkg;

  // ----------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned LIMIT_W     = 13;
  localparam int unsigned PAGE_SHIFT  = 10;   // One page is 0x400
  localparam int unsigned NUM_TRAPS   = 6;
  localparam int unsigned NUM_IRQS    = 246;
  localparam int unsigned SRC_W       = 8;

  // ----------------------------------------------------------------------
  // Addresses and offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RESET_ADDR       = 24'h000000;
  localparam logic [ADDR_W-1:0] PRIMARY_BASE     = 24'h000000;
  localparam logic [ADDR_W-1:0] PRIMARY_FIRST    = 24'h000004;
  localparam logic [ADDR_W-1:0] OFS_OSC_FAIL     = 24'h000004;
  localparam logic [ADDR_W-1:0] OFS_ADDR_ERR     = 24'h000006;
  localparam logic [ADDR_W-1:0] OFS_HARD_TRAP    = 24'h000008;
  localparam logic [ADDR_W-1:0] OFS_STACK_ERR    = 24'h00000A;
  localparam logic [ADDR_W-1:0] OFS_MATH_ERR     = 24'h00000C;
  localparam logic [ADDR_W-1:0] OFS_SOFT_TRAP    = 24'h000010;
  localparam logic [ADDR_W-1:0] OFS_IRQ0         = 24'h000014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_LAST     = 24'h0001FE;
  localparam logic [LIMIT_W-1:0] MIN_BOOT_PAGES  = 13'h0002;

  // ----------------------------------------------------------------------
  // Trap request bit positions, highest natural priority first
  // ----------------------------------------------------------------------
  localparam int unsigned TRAP_OSC_FAIL  = 0;
  localparam int unsigned TRAP_ADDR_ERR  = 1;
  localparam int unsigned TRAP_HARD      = 2;
  localparam int unsigned TRAP_STACK_ERR = 3;
  localparam int unsigned TRAP_MATH_ERR  = 4;
  localparam int unsigned TRAP_SOFT      = 5;

endpackage : vec_addr_pkg

// >>> cpu_fetch_model.sv
// Behavioural model of the CPU vector fetch side of the vector generator.
// Assumes a single ref clock and that the bench steers it through go_i.
`timescale 1ns/1ps

module cpu_fetch_model
  import vec_addr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              go_i,
  input  wire logic              grant_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic                   req_o,
  output logic                   served_o,
  output logic [ADDR_W-1:0]      got_o
);
  // ----------------------------------------------------------------------
  // Request held from a falling edge until the grant is sampled high
  // ----------------------------------------------------------------------
  always @(negedge clk_i) begin
    req_o <= go_i && !served_o && !reset_i;
  end

  // Address taken at the very edge that sees the grant
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      served_o <= 1'b0;
      got_o    <= 24'hFFFFFF;  // Poisoned so a missed capture shows
    end else if (req_o && grant_i) begin
      served_o <= 1'b1;
      got_o    <= addr_i;
    end else if (!go_i) begin
      served_o <= 1'b0;
    end
  end
endmodule // cpu_fetch_model

// >>> reset_and_alt_vector_address_tb.sv
// Self-checking bench for the reset and vector address generator.
// Assumes the CPU fetch model file is compiled before this one.
`timescale 1ns/1ps

module reset_and_alt_vector_address_tb;
  import vec_addr_pkg::*;
  logic clk, rst, cfg, en, go, force_pc, pend, is_trap, alt, grant, req;
  logic served;
  logic [LIMIT_W-1:0]   lim;
  logic [NUM_TRAPS-1:0] trap;
  logic [NUM_IRQS-1:0]  irq;
  logic [ADDR_W-1:0]    pc_start, vaddr, got;
  logic [SRC_W-1:0]     src;
  int err_count, checked;

  reset_and_alt_vector_address dut (.ref_clk_i(clk), .reset_i(rst),
    .boot_segment_limit_i(lim), .alt_table_config_bit_i(cfg),
    .alt_table_enable_i(en), .trap_req_i(trap), .irq_req_i(irq),
    .vec_fetch_req_i(req), .pc_force_o(force_pc), .pc_start_o(pc_start),
    .vec_pending_o(pend), .vec_is_trap_o(is_trap), .vec_src_o(src),
    .vec_addr_o(vaddr), .alt_active_o(alt), .vec_grant_o(grant));
  cpu_fetch_model cpu (.clk_i(clk), .reset_i(rst), .go_i(go),
    .grant_i(grant), .addr_i(vaddr), .req_o(req), .served_o(served),
    .got_o(got));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(string nm, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait so a missing grant cannot hang the run
  task automatic fetch(logic [ADDR_W-1:0] e);
    go <= 1'b1;
    repeat (20) begin
      @(negedge clk);
      if (served === 1'b1) break;
    end
    go <= 1'b0;
    @(negedge clk);
    chk("fetch_addr", e, got);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rst = 1'b1;
    trap = 6'h01;
    go <= 1'b1;
    repeat (10) @(negedge clk);
    chk("pc_force", 24'h1, {23'h0, force_pc});
    chk("pc_start", RESET_ADDR, pc_start);
    chk("vec_addr", 24'h0, vaddr);
    chk("grant", 24'h0, {23'h0, grant});
    chk("pending", 24'h0, {23'h0, pend});
    go <= 1'b0;
    rst = 1'b0;
    trap = 6'h00;
    @(negedge clk);
    chk("pc_force", 24'h0, {23'h0, force_pc});
  endtask

  task automatic t_traps;
    logic [ADDR_W-1:0] ofs [6] = '{OFS_OSC_FAIL, OFS_ADDR_ERR,
      OFS_HARD_TRAP, OFS_STACK_ERR, OFS_MATH_ERR, OFS_SOFT_TRAP};
    for (int i = 0; i < 6; i++) begin
      trap = 6'h01 << i;
      @(negedge clk);
      chk("trap_addr", ofs[i], vaddr);
      chk("trap_src", 24'(i), {16'h0, src});
    end
    trap = 6'h00;
  endtask

  task automatic t_irq;
    int ns [3] = '{0, 3, 245};
    foreach (ns[k]) begin
      irq = '0;
      irq[ns[k]] = 1'b1;
      @(negedge clk);
      chk("irq_addr", OFS_IRQ0 + 24'(2 * ns[k]), vaddr);
      fetch(OFS_IRQ0 + 24'(2 * ns[k]));
    end
    irq = '0;
  endtask

  task automatic t_prio;
    trap = 6'h30;
    irq[0] = 1'b1;
    @(negedge clk);
    chk("prio_trap", OFS_MATH_ERR, vaddr);
    chk("prio_is_trap", 24'h1, {23'h0, is_trap});
    trap = 6'h00;
    irq = '0;
    irq[9] = 1'b1;
    irq[5] = 1'b1;
    @(negedge clk);
    chk("prio_irq", 24'h00001E, vaddr);
    chk("prio_is_irq", 24'h0, {23'h0, is_trap});
    chk("prio_src", 24'h5, {16'h0, src});
    chk("prio_pend", 24'h1, {23'h0, pend});
    irq = '0;
    @(negedge clk);
    chk("idle_pend", 24'h0, {23'h0, pend});
  endtask

  task automatic t_alt;
    logic [LIMIT_W-1:0] l [6] = '{13'h0003, 13'h1FFF, 13'h0003, 13'h0003,
      13'h0001, 13'h0002};
    logic c [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic n [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [ADDR_W-1:0] e [6] = '{24'h000804, 24'h7FF804, 24'h000004,
      24'h000004, 24'h000004, 24'h000404};
    trap = 6'h01;
    for (int i = 0; i < 6; i++) begin
      lim = l[i];
      cfg = c[i];
      en = n[i];
      @(negedge clk);
      chk("alt_addr", e[i], vaddr);
      chk("alt_on", {23'h0, e[i] > 24'h4}, {23'h0, alt});
    end
    fetch(24'h000404);
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // 10 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run is a few dozen cycles; limit leaves wide margin
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end

  initial begin
    // Reset stands from time zero so no false release edge is seen
    rst = 1'b1;
    {cfg, en, go, trap, irq} = '0;
    lim = 13'h0003;
    err_count = 0;
    checked = 0;
    @(negedge clk);
    t_reset();
    t_traps();
    t_irq();
    t_prio();
    t_alt();
    t_reset();
    wrap_up();
  end
endmodule // reset_and_alt_vector_address_tb
